// [hdl/rtd_pkg.sv]
// constants and register map of the ring trip detector
//
// Operation
// - samples are processed only while the linefeed shadow shows ringing.
// - detector input is the loop current sample, readable in register 79.
// - a low-pass filter with 13-bit coefficient removes ac content.
// - filter output is compared with the 6-bit threshold in indirect 29.
// - debounce flips only if opposite input lasts the whole 7-bit interval.
// - a satisfied debounce sets the trip detect status bit in register 68.
// - the ring trip detect status bit is read-only to software.
// - a valid ring trip sets pending bit in 19 only if enable in 22.
// - threshold and coefficient are reached only via direct 28 to 31.
// - writing 1 clears a pending bit; writing 0 leaves it unchanged.
// - interrupt pin is low while any pending bit is set.
package rtd_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned LCS_W = 6;
	localparam int unsigned THR_W = 6;
	localparam int unsigned COEF_W = 13;
	localparam int unsigned DBI_W = 7;
	localparam int unsigned LF_W = 3;
	localparam int unsigned ACC_W = LCS_W + COEF_W;

	// ************************************************************
	// direct register offsets
	// ************************************************************
	localparam logic [6:0] ADDR_IRQ_PEND = 7'h13;
	localparam logic [6:0] ADDR_IRQ_EN = 7'h16;
	localparam logic [6:0] ADDR_IND_DATA_LO = 7'h1C;
	localparam logic [6:0] ADDR_IND_DATA_HI = 7'h1D;
	localparam logic [6:0] ADDR_IND_WR_ADDR = 7'h1E;
	localparam logic [6:0] ADDR_IND_RD_ADDR = 7'h1F;
	localparam logic [6:0] ADDR_LINEFEED = 7'h40;
	localparam logic [6:0] ADDR_DETECT_STATE = 7'h44;
	localparam logic [6:0] ADDR_DEBOUNCE = 7'h46;
	localparam logic [6:0] ADDR_LOOP_CURRENT = 7'h4F;

	// ************************************************************
	// indirect register offsets
	// ************************************************************
	localparam logic [7:0] IND_THRESHOLD = 8'h1D;
	localparam logic [7:0] IND_FILTER_COEFF = 8'h24;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int unsigned TRIP_PEND_BIT = 0;
	localparam int unsigned TRIP_EN_BIT = 0;
	localparam int unsigned TRIP_DET_BIT = 1;
	localparam int unsigned LF_CTRL_LSB = 0;
	localparam int unsigned LF_SHADOW_LSB = 4;
	localparam int unsigned THR_LSB = 8;
	localparam int unsigned COEF_LSB = 3;

	// ************************************************************
	// encodings and reset values
	// ************************************************************
	localparam logic [2:0] LF_RINGING = 3'h4;
	localparam logic [2:0] LF_RESET = 3'h0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [6:0] DBI_RESET = 7'h00;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned DB_TICK_NS = 1000000;
	localparam int unsigned DB_TICK_CYC = DB_TICK_NS / CLK_PERIOD_NS;

endpackage : rtd_pkg

// [hdl/rtd_debounce.sv]
// debounce filter for the ring trip comparator
`timescale 1ns/100ps
module rtd_debounce (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic clear_i,
	input wire logic tick_i,
	input wire logic level_i,
	input wire logic [rtd_pkg::DBI_W-1:0] interval_i,
	output logic level_o
);

	logic [rtd_pkg::DBI_W-1:0] cnt_ff;
	logic [rtd_pkg::DBI_W-1:0] nxt_cnt;
	logic out_ff;
	logic nxt_out;

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_out = out_ff;
		if (clear_i) begin
			nxt_cnt = '0;
			nxt_out = 1'b0;
		end else if (level_i == out_ff) begin
			// any return to the present state restarts the interval
			nxt_cnt = '0;
		end else if (cnt_ff >= interval_i) begin
			nxt_out = level_i;
			nxt_cnt = '0;
		end else if (tick_i) begin
			nxt_cnt = cnt_ff + 7'h01;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cnt_ff <= rtd_pkg::DBI_RESET;
			out_ff <= 1'b0;
		end else if (ce_i) begin
			cnt_ff <= nxt_cnt;
			out_ff <= nxt_out;
		end
	end

	assign level_o = out_ff;

endmodule : rtd_debounce

// [hdl/rtd_ring_trip_detector.sv]
// ring trip detector: register file, loop current filter, threshold, irq
`timescale 1ns/100ps
module rtd_ring_trip_detector #(
	parameter int unsigned TICK_CYC = rtd_pkg::DB_TICK_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [rtd_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [rtd_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	output logic [rtd_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic sample_valid_i,
	input wire logic [rtd_pkg::LCS_W-1:0] loop_current_sample_i,
	output logic trip_detected_flag_o,
	output logic irq_n_o
);

	localparam int unsigned TICK_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
	localparam int unsigned PROD_W = rtd_pkg::ACC_W + rtd_pkg::COEF_W + 2;
	localparam int unsigned SUM_W = rtd_pkg::ACC_W + 2;

	// ************************************************************
	// register state
	// ************************************************************
	logic trip_irq_pending_ff;
	logic nxt_trip_irq_pending;
	logic trip_irq_enable_ff;
	logic nxt_trip_irq_enable;
	logic [7:0] ind_data_lo_ff;
	logic [7:0] nxt_ind_data_lo;
	logic [7:0] ind_data_hi_ff;
	logic [7:0] nxt_ind_data_hi;
	logic [7:0] ind_wr_addr_ff;
	logic [7:0] nxt_ind_wr_addr;
	logic [7:0] ind_rd_addr_ff;
	logic [7:0] nxt_ind_rd_addr;
	logic [15:0] trip_threshold_word_ff;
	logic [15:0] nxt_trip_threshold_word;
	logic [15:0] trip_filter_coeff_word_ff;
	logic [15:0] nxt_trip_filter_coeff_word;
	logic [rtd_pkg::LF_W-1:0] linefeed_ctrl_ff;
	logic [rtd_pkg::LF_W-1:0] nxt_linefeed_ctrl;
	logic [rtd_pkg::LF_W-1:0] linefeed_shadow_ff;
	logic [rtd_pkg::LF_W-1:0] nxt_linefeed_shadow;
	logic [rtd_pkg::DBI_W-1:0] trip_debounce_interval_ff;
	logic [rtd_pkg::DBI_W-1:0] nxt_trip_debounce_interval;
	logic [rtd_pkg::LCS_W-1:0] loop_current_sample_ff;
	logic [rtd_pkg::LCS_W-1:0] nxt_loop_current_sample;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic irq_n_ff;
	logic nxt_irq_n;

	// ************************************************************
	// datapath state
	// ************************************************************
	logic [rtd_pkg::ACC_W-1:0] flt_acc_ff;
	logic [rtd_pkg::ACC_W-1:0] nxt_flt_acc;
	logic cmp_ff;
	logic nxt_cmp;
	logic [TICK_W-1:0] tick_cnt_ff;
	logic [TICK_W-1:0] nxt_tick_cnt;
	logic tick_ff;
	logic nxt_tick;
	logic det_prev_ff;
	logic nxt_det_prev;

	// ************************************************************
	// decoded fields and helpers
	// ************************************************************
	logic ringing;
	logic det_level;
	logic trip_rise;
	logic wr_pend_clear;
	logic [rtd_pkg::THR_W-1:0] trip_threshold;
	logic [rtd_pkg::COEF_W-1:0] trip_filter_coeff;
	logic [rtd_pkg::LCS_W-1:0] flt_out;
	logic signed [rtd_pkg::ACC_W:0] flt_diff;
	logic signed [rtd_pkg::ACC_W+rtd_pkg::COEF_W+1:0] flt_prod;
	logic signed [rtd_pkg::ACC_W+1:0] flt_sum;

	assign ringing = (linefeed_shadow_ff == rtd_pkg::LF_RINGING);
	assign trip_threshold = trip_threshold_word_ff[
		rtd_pkg::THR_LSB +: rtd_pkg::THR_W];
	assign trip_filter_coeff = trip_filter_coeff_word_ff[
		rtd_pkg::COEF_LSB +: rtd_pkg::COEF_W];
	assign flt_out = flt_acc_ff[rtd_pkg::ACC_W-1 -: rtd_pkg::LCS_W];
	assign wr_pend_clear = reg_wr_i && (reg_addr_i == rtd_pkg::ADDR_IRQ_PEND)
		&& reg_wdata_i[rtd_pkg::TRIP_PEND_BIT];
	assign trip_rise = det_level && !det_prev_ff;

	// ************************************************************
	// register writes, including the indirect access window
	// ************************************************************
	always_comb begin
		nxt_trip_irq_enable = trip_irq_enable_ff;
		nxt_ind_data_lo = ind_data_lo_ff;
		nxt_ind_data_hi = ind_data_hi_ff;
		nxt_ind_wr_addr = ind_wr_addr_ff;
		nxt_ind_rd_addr = ind_rd_addr_ff;
		nxt_trip_threshold_word = trip_threshold_word_ff;
		nxt_trip_filter_coeff_word = trip_filter_coeff_word_ff;
		nxt_linefeed_ctrl = linefeed_ctrl_ff;
		nxt_trip_debounce_interval = trip_debounce_interval_ff;
		// the shadow lags the control field by one cycle, as the
		// linefeed itself would take effect after the write
		nxt_linefeed_shadow = linefeed_ctrl_ff;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				rtd_pkg::ADDR_IRQ_EN: begin
					nxt_trip_irq_enable = reg_wdata_i[rtd_pkg::TRIP_EN_BIT];
				end
				rtd_pkg::ADDR_IND_DATA_LO: begin
					nxt_ind_data_lo = reg_wdata_i;
				end
				rtd_pkg::ADDR_IND_DATA_HI: begin
					nxt_ind_data_hi = reg_wdata_i;
				end
				rtd_pkg::ADDR_IND_WR_ADDR: begin
					// writing the address commits the staged data word
					nxt_ind_wr_addr = reg_wdata_i;
					if (reg_wdata_i == rtd_pkg::IND_THRESHOLD) begin
						nxt_trip_threshold_word =
							{ind_data_hi_ff, ind_data_lo_ff};
					end
					if (reg_wdata_i == rtd_pkg::IND_FILTER_COEFF) begin
						nxt_trip_filter_coeff_word =
							{ind_data_hi_ff, ind_data_lo_ff};
					end
				end
				rtd_pkg::ADDR_IND_RD_ADDR: begin
					// unknown indirect addresses read back as zero
					nxt_ind_rd_addr = reg_wdata_i;
					nxt_ind_data_lo = rtd_pkg::BYTE_RESET;
					nxt_ind_data_hi = rtd_pkg::BYTE_RESET;
					if (reg_wdata_i == rtd_pkg::IND_THRESHOLD) begin
						{nxt_ind_data_hi, nxt_ind_data_lo} =
							trip_threshold_word_ff;
					end
					if (reg_wdata_i == rtd_pkg::IND_FILTER_COEFF) begin
						{nxt_ind_data_hi, nxt_ind_data_lo} =
							trip_filter_coeff_word_ff;
					end
				end
				rtd_pkg::ADDR_LINEFEED: begin
					nxt_linefeed_ctrl =
						reg_wdata_i[rtd_pkg::LF_CTRL_LSB +: rtd_pkg::LF_W];
				end
				rtd_pkg::ADDR_DEBOUNCE: begin
					nxt_trip_debounce_interval =
						reg_wdata_i[rtd_pkg::DBI_W-1:0];
				end
				// status, sample and pending writes change nothing here
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// read mux, one cycle after the address
	// ************************************************************
	always_comb begin
		nxt_rdata = rtd_pkg::BYTE_RESET;
		unique case (reg_addr_i)
			rtd_pkg::ADDR_IRQ_PEND:
				nxt_rdata[rtd_pkg::TRIP_PEND_BIT] = trip_irq_pending_ff;
			rtd_pkg::ADDR_IRQ_EN:
				nxt_rdata[rtd_pkg::TRIP_EN_BIT] = trip_irq_enable_ff;
			rtd_pkg::ADDR_IND_DATA_LO:
				nxt_rdata = ind_data_lo_ff;
			rtd_pkg::ADDR_IND_DATA_HI:
				nxt_rdata = ind_data_hi_ff;
			rtd_pkg::ADDR_IND_WR_ADDR:
				nxt_rdata = ind_wr_addr_ff;
			rtd_pkg::ADDR_IND_RD_ADDR:
				nxt_rdata = ind_rd_addr_ff;
			rtd_pkg::ADDR_LINEFEED: begin
				nxt_rdata[rtd_pkg::LF_CTRL_LSB +: rtd_pkg::LF_W] =
					linefeed_ctrl_ff;
				nxt_rdata[rtd_pkg::LF_SHADOW_LSB +: rtd_pkg::LF_W] =
					linefeed_shadow_ff;
			end
			rtd_pkg::ADDR_DETECT_STATE:
				nxt_rdata[rtd_pkg::TRIP_DET_BIT] = det_level;
			rtd_pkg::ADDR_DEBOUNCE:
				nxt_rdata[rtd_pkg::DBI_W-1:0] = trip_debounce_interval_ff;
			rtd_pkg::ADDR_LOOP_CURRENT:
				nxt_rdata[rtd_pkg::LCS_W-1:0] =
					loop_current_sample_ff;
			default:
				nxt_rdata = rtd_pkg::BYTE_RESET;
		endcase
	end

	// ************************************************************
	// loop current filter and threshold
	// ************************************************************
	always_comb begin
		nxt_loop_current_sample = loop_current_sample_ff;
		nxt_flt_acc = flt_acc_ff;
		nxt_cmp = cmp_ff;
		// first order step: acc += (x - acc) * coeff / 2**COEF_W;
		// coeff below 2**COEF_W keeps acc between old acc and x
		flt_diff = $signed({1'b0, loop_current_sample_i,
			{rtd_pkg::COEF_W{1'b0}}}) - $signed({1'b0, flt_acc_ff});
		flt_prod = PROD_W'(flt_diff)
			* PROD_W'($signed({1'b0, trip_filter_coeff}));
		flt_sum = SUM_W'($signed({2'b00, flt_acc_ff})
			+ (flt_prod >>> rtd_pkg::COEF_W));
		if (sample_valid_i) begin
			nxt_loop_current_sample = loop_current_sample_i;
		end
		if (!ringing) begin
			// restart from zero so stale current cannot trip the next ring
			nxt_flt_acc = '0;
			nxt_cmp = 1'b0;
		end else if (sample_valid_i) begin
			nxt_flt_acc = flt_sum[rtd_pkg::ACC_W-1:0];
			nxt_cmp = (flt_out > trip_threshold);
		end
	end

	// ************************************************************
	// debounce time base
	// ************************************************************
	always_comb begin
		nxt_tick = 1'b0;
		nxt_tick_cnt = tick_cnt_ff + TICK_W'(1);
		if (!ringing) begin
			nxt_tick_cnt = '0;
		end else if (tick_cnt_ff == TICK_LAST) begin
			nxt_tick_cnt = '0;
			nxt_tick = 1'b1;
		end
	end

	rtd_debounce u_debounce (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.clear_i(!ringing),
		.tick_i(tick_ff),
		.level_i(cmp_ff),
		.interval_i(trip_debounce_interval_ff),
		.level_o(det_level)
	);

	// ************************************************************
	// interrupt pending and pin
	// ************************************************************
	always_comb begin
		nxt_det_prev = det_level;
		nxt_trip_irq_pending = trip_irq_pending_ff;
		if (wr_pend_clear) begin
			nxt_trip_irq_pending = 1'b0;
		end
		// a new trip in the clearing cycle still wins
		if (trip_rise && trip_irq_enable_ff) begin
			nxt_trip_irq_pending = 1'b1;
		end
		nxt_irq_n = !nxt_trip_irq_pending;
	end

	// ************************************************************
	// state registers
	// ************************************************************
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			trip_irq_pending_ff <= 1'b0;
			trip_irq_enable_ff <= 1'b0;
			ind_data_lo_ff <= rtd_pkg::BYTE_RESET;
			ind_data_hi_ff <= rtd_pkg::BYTE_RESET;
			ind_wr_addr_ff <= rtd_pkg::BYTE_RESET;
			ind_rd_addr_ff <= rtd_pkg::BYTE_RESET;
			trip_threshold_word_ff <= rtd_pkg::WORD_RESET;
			trip_filter_coeff_word_ff <= rtd_pkg::WORD_RESET;
			linefeed_ctrl_ff <= rtd_pkg::LF_RESET;
			linefeed_shadow_ff <= rtd_pkg::LF_RESET;
			trip_debounce_interval_ff <= rtd_pkg::DBI_RESET;
			loop_current_sample_ff <= '0;
			rdata_ff <= rtd_pkg::BYTE_RESET;
			irq_n_ff <= 1'b1;
			flt_acc_ff <= '0;
			cmp_ff <= 1'b0;
			tick_cnt_ff <= '0;
			tick_ff <= 1'b0;
			det_prev_ff <= 1'b0;
		end else if (ce_i) begin
			trip_irq_pending_ff <= nxt_trip_irq_pending;
			trip_irq_enable_ff <= nxt_trip_irq_enable;
			ind_data_lo_ff <= nxt_ind_data_lo;
			ind_data_hi_ff <= nxt_ind_data_hi;
			ind_wr_addr_ff <= nxt_ind_wr_addr;
			ind_rd_addr_ff <= nxt_ind_rd_addr;
			trip_threshold_word_ff <= nxt_trip_threshold_word;
			trip_filter_coeff_word_ff <= nxt_trip_filter_coeff_word;
			linefeed_ctrl_ff <= nxt_linefeed_ctrl;
			linefeed_shadow_ff <= nxt_linefeed_shadow;
			trip_debounce_interval_ff <= nxt_trip_debounce_interval;
			loop_current_sample_ff <= nxt_loop_current_sample;
			rdata_ff <= nxt_rdata;
			irq_n_ff <= nxt_irq_n;
			flt_acc_ff <= nxt_flt_acc;
			cmp_ff <= nxt_cmp;
			tick_cnt_ff <= nxt_tick_cnt;
			tick_ff <= nxt_tick;
			det_prev_ff <= nxt_det_prev;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign irq_n_o = irq_n_ff;
	assign trip_detected_flag_o = det_level;

endmodule : rtd_ring_trip_detector

// [verif/rtd_ring_trip_detector_chk.sv]
// port checker of the ring trip detector, bound to its top module
`timescale 1ns/100ps
module rtd_ring_trip_detector_chk #(
	parameter int unsigned TICK_CYC = rtd_pkg::DB_TICK_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [rtd_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [rtd_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic [rtd_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic sample_valid_i,
	input wire logic [rtd_pkg::LCS_W-1:0] loop_current_sample_i,
	input wire logic trip_detected_flag_o,
	input wire logic irq_n_o
);
	// ********
	// linefeed and last sample as the bus set them
	// ********
	logic ring_ff;
	logic nxt_ring;
	logic [3:0] rcnt_ff;
	logic [3:0] nxt_rcnt;
	logic [5:0] smp_ff;
	logic [5:0] nxt_smp;
	logic wr_ok;
	logic clr_w;
	assign wr_ok = ce_i && reg_wr_i;
	assign clr_w = wr_ok && reg_addr_i == 7'h13 && reg_wdata_i[0];
	always_comb begin
		nxt_ring = ring_ff;
		nxt_smp = smp_ff;
		if (wr_ok && reg_addr_i == rtd_pkg::ADDR_LINEFEED) begin
			nxt_ring = reg_wdata_i[2:0] == rtd_pkg::LF_RINGING;
		end
		if (ce_i && sample_valid_i) begin
			nxt_smp = loop_current_sample_i;
		end
		// saturates so long ringing never wraps back under the bound
		nxt_rcnt = rcnt_ff + {3'h0, rcnt_ff != 4'hF};
		if (!nxt_ring || !ring_ff) begin
			nxt_rcnt = 4'h0;
		end
		if (rst_i && ce_i) begin
			nxt_ring = 1'b0;
			nxt_smp = 6'h00;
			nxt_rcnt = 4'h0;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		ring_ff <= nxt_ring;
		rcnt_ff <= nxt_rcnt;
		smp_ff <= nxt_smp;
	end
	// ********
	// assertions
	// ********
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_clr;
		clr_w && !$rose(trip_detected_flag_o);
	endsequence
	sequence s_ring_off;
		wr_ok && reg_addr_i == 7'h40 && reg_wdata_i[2:0] != 3'h4;
	endsequence
	chk_irq_clear: assert property (s_clr |=> irq_n_o)
		else $error("irq still low after clear");
	chk_irq_hold: assert property (!irq_n_o && !clr_w |=> !irq_n_o)
		else $error("irq released without clear");
	chk_irq_rise: assert property (
		$rose(irq_n_o) |-> $past(clr_w))
		else $error("irq released by no clear write");
	chk_irq_cause: assert property (
		$fell(irq_n_o) |-> $past(trip_detected_flag_o))
		else $error("irq without detect");
	chk_trip_off: assert property (
		s_ring_off |-> ##[1:3] !trip_detected_flag_o)
		else $error("detect kept after ringing left");
	chk_trip_arm: assert property (
		$rose(trip_detected_flag_o) |-> ring_ff && rcnt_ff > 4'h2)
		else $error("detect outside ringing");
	chk_det_read: assert property (
		ce_i && reg_addr_i == 7'h44
		|=> reg_rdata_o[1] == $past(trip_detected_flag_o))
		else $error("status bit differs from detect");
	chk_pend_read: assert property (
		ce_i && reg_addr_i == 7'h13
		|=> reg_rdata_o[0] == !$past(irq_n_o))
		else $error("pending bit differs from irq pin");
	chk_smp_read: assert property (
		ce_i && reg_addr_i == 7'h4F && !sample_valid_i
		|=> reg_rdata_o == {2'b00, smp_ff})
		else $error("sample register wrong");
	chk_ce_hold: assert property (
		!ce_i |=> $stable(reg_rdata_o) && $stable(irq_n_o))
		else $error("outputs moved while frozen");
endmodule : rtd_ring_trip_detector_chk

bind rtd_ring_trip_detector rtd_ring_trip_detector_chk #(.TICK_CYC(TICK_CYC))
	u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i),
	.loop_current_sample_i(loop_current_sample_i),
	.trip_detected_flag_o(trip_detected_flag_o), .irq_n_o(irq_n_o));

// [verif/rtd_lcm_model.sv]
// behavioural loop current monitor converter feeding the detector
`timescale 1ns/100ps
module rtd_lcm_model (
	input wire logic ref_clk_i,
	input wire logic en_i,
	input wire logic [3:0] gap_i,
	input wire logic [5:0] level_i,
	output logic sample_valid_o,
	output logic [5:0] sample_o
);
	// ********
	// sample pacing
	// ********
	logic [3:0] cnt = 4'h0;
	always @(negedge ref_clk_i) begin
		if (en_i && cnt >= gap_i) begin
			sample_valid_o <= 1'b1;
			sample_o <= level_i;
			cnt <= 4'h0;
		end else begin
			sample_valid_o <= 1'b0;
			// nothing is held between strobes, so a stale read shows up
			sample_o <= ~sample_o;
			cnt <= cnt + 4'h1;
		end
	end
endmodule : rtd_lcm_model

// [verif/rtd_ring_trip_detector_tb.sv]
// self-checking bench of the ring trip detector
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
$display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end
module rtd_ring_trip_detector_tb;
	int n_fail = 0;
	int n_tests = 0;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic wr = 1'b0;
	logic [6:0] addr = 7'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic sv;
	logic [5:0] smp;
	logic trip;
	logic irq_n;
	logic m_en = 1'b0;
	logic [3:0] m_gap = 4'h3;
	logic [5:0] m_lvl = 6'h3F;
	logic [7:0] rd_v;
	logic [15:0] w_v;
	rtd_ring_trip_detector #(.TICK_CYC(4)) DUT (
		.ref_clk_i(clk), .rst_i(rst), .ce_i(ce), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rdata_o(rdata),
		.sample_valid_i(sv), .loop_current_sample_i(smp),
		.trip_detected_flag_o(trip), .irq_n_o(irq_n));
	rtd_lcm_model u_lcm (
		.ref_clk_i(clk), .en_i(m_en), .gap_i(m_gap), .level_i(m_lvl),
		.sample_valid_o(sv), .sample_o(smp));
	// ********
	// bus and check tasks
	// ********
	task automatic stop_test();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		d = rdata;
	endtask : rd_reg
	task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
		rd_reg(a, rd_v);
		`CHK(rd_v, e)
	endtask : chk_rd
	task automatic ind_wr(input logic [7:0] ia, input logic [15:0] w);
		wr_reg(7'h1C, w[7:0]);
		wr_reg(7'h1D, w[15:8]);
		wr_reg(7'h1E, ia);
	endtask : ind_wr
	task automatic ind_chk(input logic [7:0] ia, input logic [15:0] e);
		wr_reg(7'h1F, ia);
		rd_reg(7'h1C, w_v[7:0]);
		rd_reg(7'h1D, w_v[15:8]);
		`CHK(w_v, e)
	endtask : ind_chk
	task automatic wait_trip(input logic v, input int n);
		for (int i = 0; i < n && trip !== v; i++) @(negedge clk);
		`CHK(trip, v)
	endtask : wait_trip
	// ********
	// scenarios
	// ********
	task automatic t_regs();
		`CHK(irq_n, 1'b1)
		chk_rd(7'h13, 8'h00);
		wr_reg(7'h05, 8'hFF);
		chk_rd(7'h05, 8'h00);
		wr_reg(7'h46, 8'h0B);
		chk_rd(7'h46, 8'h0B);
		wr_reg(7'h44, 8'hFF);
		chk_rd(7'h44, 8'h00);
		wr_reg(7'h4F, 8'hFF);
		chk_rd(7'h4F, 8'h00);
		ind_wr(8'h1D, 16'h3600);
		ind_wr(8'h24, 16'h0320);
		ind_chk(8'h1D, 16'h3600);
		ind_chk(8'h24, 16'h0320);
		ind_chk(8'h30, 16'h0000);
		wr_reg(7'h40, 8'h04);
		chk_rd(7'h40, 8'h44);
		wr_reg(7'h40, 8'h00);
	endtask : t_regs
	task automatic t_idle();
		// fast filter and no debounce, so only the ringing gate holds trip
		ind_wr(8'h24, 16'hFFF8);
		wr_reg(7'h46, 8'h00);
		m_en <= 1'b1;
		repeat (60) @(negedge clk);
		`CHK(trip, 1'b0)
		chk_rd(7'h4F, 8'h3F);
	endtask : t_idle
	task automatic t_filter();
		ind_wr(8'h1D, 16'h1400);
		wr_reg(7'h46, 8'h05);
		ind_wr(8'h24, 16'h0000);
		wr_reg(7'h40, 8'h04);
		repeat (60) @(negedge clk);
		`CHK(trip, 1'b0)
		ind_wr(8'h24, 16'hFFF8);
		// settle from above so that a >= compare would trip
		repeat (8) @(negedge clk);
		m_lvl <= 6'h14;
		repeat (200) @(negedge clk);
		`CHK(trip, 1'b0)
		wr_reg(7'h40, 8'h00);
	endtask : t_filter
	task automatic t_trip();
		m_gap <= 4'h0;
		m_lvl <= 6'h28;
		wr_reg(7'h16, 8'h01);
		chk_rd(7'h16, 8'h01);
		wr_reg(7'h40, 8'h04);
		repeat (10) @(negedge clk);
		`CHK(trip, 1'b0)
		wait_trip(1'b1, 80);
		`CHK(irq_n, 1'b1)
		@(negedge clk);
		`CHK(irq_n, 1'b0)
		chk_rd(7'h44, 8'h02);
		chk_rd(7'h13, 8'h01);
		wr_reg(7'h13, 8'h00);
		`CHK(irq_n, 1'b0)
		wr_reg(7'h13, 8'h01);
		`CHK(irq_n, 1'b1)
		m_lvl <= 6'h00;
		repeat (2) @(negedge clk);
		m_lvl <= 6'h28;
		repeat (30) @(negedge clk);
		`CHK(trip, 1'b1)
		m_lvl <= 6'h00;
		wait_trip(1'b0, 80);
		m_lvl <= 6'h28;
		wait_trip(1'b1, 80);
		@(negedge clk);
		`CHK(irq_n, 1'b0)
		wr_reg(7'h40, 8'h00);
		wait_trip(1'b0, 4);
		`CHK(irq_n, 1'b0)
		wr_reg(7'h13, 8'h01);
		wr_reg(7'h16, 8'h00);
		wr_reg(7'h40, 8'h04);
		wait_trip(1'b1, 80);
		repeat (3) @(negedge clk);
		`CHK(irq_n, 1'b1)
		wr_reg(7'h16, 8'h01);
		chk_rd(7'h13, 8'h00);
		ce = 1'b0;
		wr_reg(7'h16, 8'h00);
		ce = 1'b1;
		chk_rd(7'h16, 8'h01);
		wr_reg(7'h40, 8'h00);
	endtask : t_trip
	initial begin
		forever #5 clk = ~clk;
	end
	// the scenarios need under 900 cycles; over twenty times that means a hang
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		t_regs();
		t_idle();
		t_filter();
		t_trip();
		stop_test();
	end
endmodule : rtd_ring_trip_detector_tb
